// ==== logic/dacc_cfg.svh ====
// constants of the accumulator datapath
`ifndef DACC_CFG_SVH
`define DACC_CFG_SVH
`define DACC_W 40
`define DACC_MSB 39
`define DACC_GUARD_LO 32
`define DACC_HI_MSB 31
`define DACC_HI_LSB 16
`define DACC_LO_MSB 15
`define DACC_POS40 40'h7FFFFFFFFF
`define DACC_NEG40 40'h8000000000
`define DACC_POS32 40'h007FFFFFFF
`define DACC_NEG32 40'h0080000000
`define DACC_HALF 16'h8000
`define DACC_WPOS 16'h7FFF
`define DACC_WNEG 16'h8000
`define DACC_PTR_STEP 16'h0002
`define DACC_APB_CTL 12'h000
`define DACC_APB_TRAP 12'h004
`define DACC_APB_STAT 12'h008
`define DACC_APB_ACCA_L 12'h00C
`define DACC_APB_ACCA_H 12'h010
`define DACC_APB_ACCB_L 12'h014
`define DACC_APB_ACCB_H 12'h018
`define DACC_APB_WBPTR 12'h01C
`define DACC_APB_WBDATA 12'h020
`define DACC_CTL_RND 1
`define DACC_CTL_ACCSEL 4
`define DACC_CTL_STCLIP 5
`define DACC_CTL_CLIPA 6
`define DACC_CTL_CLIPB 7
`define DACC_CTL_RST 8'h01
`endif

// ==== logic/dacc_pkg.sv ====
// types of the accumulator datapath
package dacc_pkg;
  typedef logic [39:0] dacc_acc_t;
  typedef enum logic [3:0] {
    DACC_OP_NONE = 4'h1,
    DACC_OP_ADD = 4'h2,
    DACC_OP_SUB = 4'h4,
    DACC_OP_LOAD = 4'h8
  } dacc_op_e;
  typedef enum logic [1:0] {
    DACC_WB_DIRECT = 2'h1,
    DACC_WB_POSTINC = 2'h2
  } dacc_wb_e;
endpackage

// ==== logic/dacc_bus_if.sv ====
// store path signals between the accumulator core and its store unit
`timescale 1ns/10ps
interface dacc_bus_if;
  logic [39:0] src;
  logic round_en;
  logic conv_sel;
  logic clip_en;
  logic [15:0] data;
  modport core (output src, output round_en, output conv_sel, output clip_en, input data);
  modport store (input src, input round_en, input conv_sel, input clip_en, output data);
endinterface

// ==== logic/dacc_store.sv ====
// rounding and data write clipping of an accumulator word
`timescale 1ns/10ps
`include "dacc_cfg.svh"
module dacc_store (
  input wire logic pclk,
  input wire logic presetn,
  dacc_bus_if.store sb
);
  import dacc_pkg::*;
  // ----------------------------------------
  // round
  // ----------------------------------------
  wire [15:0] lo_word = sb.src[`DACC_LO_MSB:0];
  wire lo_half = lo_word[`DACC_LO_MSB];
  wire tie = (lo_word == `DACC_HALF);
  wire bump_conv = lo_half & ~(tie & ~sb.src[`DACC_HI_LSB]);
  wire bump = sb.round_en & (sb.conv_sel ? lo_half : bump_conv);
  wire [24:0] up_word = {1'b0, sb.src[`DACC_MSB:`DACC_HI_LSB]} + {24'h000000, bump};
  // ----------------------------------------
  // clip
  // ----------------------------------------
  wire sgn = sb.src[`DACC_MSB];
  wire over_pos = ~sgn & (up_word[23:15] != 9'h000);
  wire over_neg = sgn & (up_word[23:15] != 9'h1FF);
  wire [15:0] clipped = over_pos ? `DACC_WPOS : (over_neg ? `DACC_WNEG : up_word[15:0]);
  wire [15:0] word_next = sb.clip_en ? clipped : up_word[15:0];
  logic [15:0] word_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_reg <= 16'h0000;
    end else begin
      word_reg <= word_next;
    end
  end
  assign sb.data = word_reg;
endmodule

// ==== logic/dacc_top.sv ====
// accumulator datapath with saturation, rounding and write-back
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "dacc_cfg.svh"
module dacc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire dacc_pkg::dacc_op_e op_code,
  input wire logic op_target_b,
  input wire logic op_zero_acc,
  input wire logic [39:0] op_operand,
  input wire logic op_writeback,
  input wire dacc_pkg::dacc_wb_e op_wb_mode,
  input wire logic store_valid,
  input wire logic store_src_b,
  input wire logic store_rounded,
  output logic xbus_wr,
  output logic [15:0] xbus_addr,
  output logic [15:0] xbus_wdata,
  output logic arith_trap_req
);
  import dacc_pkg::*;
  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] ctl_reg;
  logic [2:0] trap_en_reg;
  logic [39:0] acc_a_reg;
  logic [39:0] acc_b_reg;
  logic [15:0] wbptr_reg;
  logic first_acc_clip_flag;
  logic second_acc_clip_flag;
  logic first_acc_guard_ovf;
  logic second_acc_guard_ovf;
  wire apb_wr = psel & penable & pwrite;
  wire clip_width_sel = ctl_reg[`DACC_CTL_ACCSEL];
  wire store_clip_en = ctl_reg[`DACC_CTL_STCLIP];
  wire round_style_sel = ctl_reg[`DACC_CTL_RND];
  wire first_acc_clip_en = ctl_reg[`DACC_CTL_CLIPA];
  wire second_acc_clip_en = ctl_reg[`DACC_CTL_CLIPB];
  wire first_guard_trap_en = trap_en_reg[0];
  wire second_guard_trap_en = trap_en_reg[1];
  wire sign_loss_trap_en = trap_en_reg[2];
  wire either_guard_ovf = first_acc_guard_ovf | second_acc_guard_ovf;
  wire either_clip_flag = first_acc_clip_flag | second_acc_clip_flag;
  // ----------------------------------------
  // adder
  // ----------------------------------------
  wire adder_op = op_valid & ((op_code == DACC_OP_ADD) | (op_code == DACC_OP_SUB));
  wire load_op = op_valid & (op_code == DACC_OP_LOAD);
  wire is_sub = (op_code == DACC_OP_SUB);
  wire [39:0] acc_src = op_target_b ? acc_b_reg : acc_a_reg;
  wire [39:0] lhs = op_zero_acc ? 40'h0000000000 : acc_src;
  wire [39:0] rhs = is_sub ? ~op_operand : op_operand;
  wire [40:0] sum = {1'b0, lhs} + {1'b0, rhs} + {40'h0000000000, is_sub};
  wire [39:0] raw = sum[39:0];
  // true sign from the pre-overflow operands and the carry
  wire true_neg = lhs[`DACC_MSB] ^ rhs[`DACC_MSB] ^ sum[40];
  wire ovf39 = (lhs[`DACC_MSB] == rhs[`DACC_MSB]) & (raw[`DACC_MSB] != lhs[`DACC_MSB]);
  wire guard_diff = ~((&raw[`DACC_MSB:`DACC_GUARD_LO]) | ~(|raw[`DACC_MSB:`DACC_GUARD_LO]));
  // 1.31 range check takes bit 31 in as well
  wire top9_diff = ~((&raw[`DACC_MSB:`DACC_HI_MSB]) | ~(|raw[`DACC_MSB:`DACC_HI_MSB]));
  wire ovf31 = top9_diff | ovf39;
  wire clip_en_t = op_target_b ? second_acc_clip_en : first_acc_clip_en;
  // ----------------------------------------
  // saturation decision
  // ----------------------------------------
  wire sat40 = clip_en_t & clip_width_sel & ovf39;
  wire sat32 = clip_en_t & ~clip_width_sel & ovf31;
  wire [39:0] lim40 = true_neg ? `DACC_NEG40 : `DACC_POS40;
  wire [39:0] lim32 = true_neg ? `DACC_NEG32 : `DACC_POS32;
  wire [39:0] result = sat40 ? lim40 : (sat32 ? lim32 : raw);
  // clip flag source: range overflow when clipping, bit 39 otherwise
  wire clip_evt = clip_en_t ? (sat40 | sat32) : ovf39;
  // 1.31 clipping keeps guard bits unused
  wire guard_new = (clip_en_t & ~clip_width_sel) ? 1'b0 : guard_diff;
  // ----------------------------------------
  // write-back and store
  // ----------------------------------------
  dacc_bus_if sbus ();
  wire wb_go = adder_op & op_writeback;
  wire [39:0] other_acc = op_target_b ? acc_a_reg : acc_b_reg;
  assign sbus.src = wb_go ? other_acc : (store_src_b ? acc_b_reg : acc_a_reg);
  assign sbus.round_en = wb_go | store_rounded;
  assign sbus.conv_sel = round_style_sel;
  assign sbus.clip_en = store_clip_en;
  dacc_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .sb(sbus)
  );
  logic wr_pend_reg;
  logic wr_ptr_reg;
  logic [15:0] wr_addr_reg;
  wire sw_ptr_wr = apb_wr & (paddr == `DACC_APB_WBPTR);
  wire wb_direct = wb_go & (op_wb_mode == DACC_WB_DIRECT);
  wire wb_post = wb_go & (op_wb_mode == DACC_WB_POSTINC);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_pend_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      wr_addr_reg <= 16'h0000;
    end else begin
      wr_pend_reg <= wb_post | (store_valid & ~wb_go);
      wr_ptr_reg <= wb_direct;
      wr_addr_reg <= wbptr_reg;
    end
  end
  wire [15:0] ptr_inc = wbptr_reg + `DACC_PTR_STEP;
  // direct mode lands the word in the pointer itself
  wire [15:0] wbptr_next = wr_ptr_reg ? sbus.data :
    (wb_post ? ptr_inc : (sw_ptr_wr ? pwdata[15:0] : wbptr_reg));
  assign xbus_wr = wr_pend_reg;
  assign xbus_addr = wr_addr_reg;
  assign xbus_wdata = sbus.data;
  // ----------------------------------------
  // flags and traps
  // ----------------------------------------
  wire stat_wr = apb_wr & (paddr == `DACC_APB_STAT);
  wire set_a = adder_op & ~op_target_b & clip_evt;
  wire set_b = adder_op & op_target_b & clip_evt;
  // set wins over a software clear in the same cycle
  wire clip_a_next = set_a | (first_acc_clip_flag & ~(stat_wr & pwdata[2]));
  wire clip_b_next = set_b | (second_acc_clip_flag & ~(stat_wr & pwdata[3]));
  wire guard_a_next = (adder_op & ~op_target_b) ? guard_new : first_acc_guard_ovf;
  wire guard_b_next = (adder_op & op_target_b) ? guard_new : second_acc_guard_ovf;
  wire trap_guard = (first_acc_guard_ovf & first_guard_trap_en)
    | (second_acc_guard_ovf & second_guard_trap_en);
  wire trap_loss = sign_loss_trap_en & ((first_acc_clip_flag & ~first_acc_clip_en)
    | (second_acc_clip_flag & ~second_acc_clip_en));
  wire [39:0] acc_new = load_op ? op_operand : result;
  wire upd_a = (adder_op | load_op) & ~op_target_b;
  wire upd_b = (adder_op | load_op) & op_target_b;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= `DACC_CTL_RST;
      trap_en_reg <= 3'h0;
      acc_a_reg <= 40'h0000000000;
      acc_b_reg <= 40'h0000000000;
      wbptr_reg <= 16'h0000;
      first_acc_clip_flag <= 1'b0;
      second_acc_clip_flag <= 1'b0;
      first_acc_guard_ovf <= 1'b0;
      second_acc_guard_ovf <= 1'b0;
      arith_trap_req <= 1'b0;
    end else begin
      if (apb_wr & (paddr == `DACC_APB_CTL)) begin
        ctl_reg <= pwdata[7:0];
      end
      if (apb_wr & (paddr == `DACC_APB_TRAP)) begin
        trap_en_reg <= pwdata[2:0];
      end
      if (upd_a) begin
        acc_a_reg <= acc_new;
      end
      if (upd_b) begin
        acc_b_reg <= acc_new;
      end
      wbptr_reg <= wbptr_next;
      first_acc_clip_flag <= clip_a_next;
      second_acc_clip_flag <= clip_b_next;
      first_acc_guard_ovf <= guard_a_next;
      second_acc_guard_ovf <= guard_b_next;
      arith_trap_req <= trap_guard | trap_loss;
    end
  end
  // ----------------------------------------
  // apb read
  // ----------------------------------------
  wire [31:0] stat_word = {26'h0000000, either_clip_flag, either_guard_ovf,
    second_acc_clip_flag, first_acc_clip_flag, second_acc_guard_ovf, first_acc_guard_ovf};
  wire [31:0] rd_mux =
    (paddr == `DACC_APB_CTL) ? {24'h000000, ctl_reg} :
    (paddr == `DACC_APB_TRAP) ? {29'h00000000, trap_en_reg} :
    (paddr == `DACC_APB_STAT) ? stat_word :
    (paddr == `DACC_APB_ACCA_L) ? acc_a_reg[31:0] :
    (paddr == `DACC_APB_ACCA_H) ? {24'h000000, acc_a_reg[39:32]} :
    (paddr == `DACC_APB_ACCB_L) ? acc_b_reg[31:0] :
    (paddr == `DACC_APB_ACCB_H) ? {24'h000000, acc_b_reg[39:32]} :
    (paddr == `DACC_APB_WBPTR) ? {16'h0000, wbptr_reg} :
    (paddr == `DACC_APB_WBDATA) ? {16'h0000, sbus.data} : 32'h00000000;
  wire addr_ok = (paddr == `DACC_APB_CTL) | (paddr == `DACC_APB_TRAP)
    | (paddr == `DACC_APB_STAT) | (paddr == `DACC_APB_ACCA_L) | (paddr == `DACC_APB_ACCA_H)
    | (paddr == `DACC_APB_ACCB_L) | (paddr == `DACC_APB_ACCB_H)
    | (paddr == `DACC_APB_WBPTR) | (paddr == `DACC_APB_WBDATA);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
endmodule

// ==== dv/dacc_xbus_mem.sv ====
// data space sink that records the word writes on the x bus
`timescale 1ns/10ps
module dacc_xbus_mem (
  input wire logic pclk,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] last_addr,
  output logic [15:0] last_data
);
  always @(posedge pclk) begin
    if (wr === 1'b1) begin
      last_addr <= addr;
      last_data <= wdata;
    end
  end
endmodule

// ==== dv/dacc_top_sva.sv ====
// port assertions for the accumulator datapath
`timescale 1ns/10ps
module dacc_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic op_valid,
  input wire dacc_pkg::dacc_op_e op_code,
  input wire logic op_writeback,
  input wire dacc_pkg::dacc_wb_e op_wb_mode,
  input wire logic store_valid,
  input wire logic xbus_wr,
  input wire logic [15:0] xbus_addr,
  input wire logic arith_trap_req
);
  import dacc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc_ph = psel && penable;
  wire logic mapped = paddr <= 12'h020 && paddr[1:0] == 2'h0;
  wire logic arith = op_code == DACC_OP_ADD || op_code == DACC_OP_SUB;
  wire logic wb_req = op_valid && op_writeback && arith;
  wire logic inc_req = wb_req && op_wb_mode == DACC_WB_POSTINC;
  wire logic cause = op_valid || acc_ph;
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc_ph && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc_ph && mapped |-> !pslverr) else $error("mapped access refused");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_store_write: assert property (store_valid && !wb_req |=> xbus_wr)
    else $error("store lost");
  a_write_cause: assert property (xbus_wr |-> $past(store_valid || wb_req))
    else $error("stray write");
  a_addr_step: assert property (inc_req ##1 inc_req |=> xbus_addr == $past(xbus_addr) + 16'h0002)
    else $error("pointer step wrong");
  a_trap_cause: assert property ($rose(arith_trap_req) |-> $past(cause) || $past(cause, 2))
    else $error("trap without cause");
  c_inc_pair: cover property (inc_req ##1 inc_req);
  c_store: cover property (store_valid && !wb_req);
  c_trap: cover property ($rose(arith_trap_req));
endmodule
bind dacc_top dacc_top_sva i_dacc_top_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .op_valid, .op_code, .op_writeback, .op_wb_mode, .store_valid,
  .xbus_wr, .xbus_addr, .arith_trap_req);

// ==== dv/tb_top.sv ====
// random and corner stimulus for the accumulator datapath
`timescale 1ns/10ps
`include "dacc_cfg.svh"
module tb_top;
  import dacc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, op_valid = 0;
  logic op_target_b = 0, op_zero_acc = 0, op_writeback = 0;
  logic store_valid = 0, store_src_b = 0, store_rounded = 0;
  logic pready, pslverr, xbus_wr, arith_trap_req, err, b, z, wb;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, r, w, seed = 32'h5F921D03;
  logic [39:0] op_operand = 0, v, acc [2];
  logic [15:0] xbus_addr, xbus_wdata, last_addr, last_data, ptr, wbd;
  logic [1:0] gd, cl;
  logic [7:0] ctl;
  logic [39:0] tv [7] = '{40'h0012348000, 40'h0012358000, 40'h001234FFFF, 40'h0012347FFF,
    40'h0100000000, 40'hFF00000000, 40'h007FFF8000};
  dacc_op_e op_code = DACC_OP_NONE, c;
  dacc_wb_e op_wb_mode = DACC_WB_POSTINC;
  int bad_count = 0, num_checks = 0;
  always #2 pclk = ~pclk;
  dacc_top i_dacc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_valid, .op_code, .op_target_b, .op_zero_acc, .op_operand,
    .op_writeback, .op_wb_mode, .store_valid, .store_src_b, .store_rounded, .xbus_wr,
    .xbus_addr, .xbus_wdata, .arith_trap_req);
  dacc_xbus_mem i_dacc_xbus_mem (.pclk, .wr(xbus_wr), .addr(xbus_addr), .wdata(xbus_wdata),
    .last_addr, .last_data);
  function automatic logic [31:0] rnd32();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] ref_st(logic [39:0] a, logic rn);
    logic [23:0] u;
    u = a[39:16] + 24'(rn && a[15] && (ctl[1] || a[15:0] != 16'h8000 || a[16]));
    if (ctl[5] && !a[39] && u > 24'h007FFF) return 16'h7FFF;
    if (ctl[5] && a[39] && u < 24'hFF8000) return 16'h8000;
    return u[15:0];
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      bad_count++;
      complete_run();
    end
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic do_op(input dacc_op_e k, input logic t, input logic zr, input logic [39:0] d,
    input logic wbk);
    logic [40:0] s;
    logic [39:0] lim;
    logic en, ov;
    s = zr ? 41'h0 : {acc[t][39], acc[t]};
    s = (k == DACC_OP_SUB) ? s - {d[39], d} : s + {d[39], d};
    en = t ? ctl[7] : ctl[6];
    ov = (en && !ctl[4]) ? (s[40:31] != 10'h0 && s[40:31] != 10'h3FF) : (s[40] != s[39]);
    lim = ctl[4] ? (s[40] ? `DACC_NEG40 : `DACC_POS40) : (s[40] ? `DACC_NEG32 : `DACC_POS32);
    acc[t] = (k == DACC_OP_LOAD) ? d : ((en && ov) ? lim : s[39:0]);
    if (k != DACC_OP_LOAD) begin
      gd[t] = s[39:32] != 8'h0 && s[39:32] != 8'hFF && !(en && !ctl[4]);
      cl[t] = cl[t] | ov;
    end
    {op_valid, op_target_b, op_zero_acc, op_operand, op_writeback} <= {1'b1, t, zr, d, wbk};
    op_code <= k;
    @(posedge pclk);
    op_valid <= 0;
    @(posedge pclk);
  endtask
  task automatic chk_state(input logic t);
    apb(0, `DACC_APB_STAT, 0);
    chk(rd, {26'h0, |cl, |gd, cl, gd});
    apb(0, t ? `DACC_APB_ACCB_L : `DACC_APB_ACCA_L, 0);
    chk(rd, acc[t][31:0]);
    apb(0, t ? `DACC_APB_ACCB_H : `DACC_APB_ACCA_H, 0);
    chk(rd, acc[t][39:32]);
  endtask
  task automatic corner(input logic [7:0] k, input logic t, input logic [39:0] d, input dacc_op_e o);
    ctl = k;
    apb(1, `DACC_APB_CTL, k);
    do_op(DACC_OP_ADD, t, 1, d, 0);
    do_op(o, t, 0, 40'h1, 0);
    chk_state(t);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `DACC_APB_CTL, 0);
    chk(rd, `DACC_CTL_RST);
    apb(0, 12'h024, 0);
    chk(err, 1'b1);
    apb(1, `DACC_APB_WBPTR, 32'h0100);
    ptr = 16'h0100;
    for (int i = 0; i < 56; i++) begin
      ctl = {2'b00, i[1], 3'b000, i[0], 1'b0};
      apb(1, `DACC_APB_CTL, ctl);
      do_op(DACC_OP_LOAD, i[3], 0, tv[i / 8], 0);
      {store_valid, store_src_b, store_rounded} <= {1'b1, i[3], i[2]};
      @(posedge pclk);
      store_valid <= 0;
      repeat (3) @(posedge pclk);
      chk(last_data, ref_st(acc[i[3]], i[2]));
      chk(last_addr, ptr);
      apb(0, i[3] ? `DACC_APB_ACCB_L : `DACC_APB_ACCA_L, 0);
      chk(rd, acc[i[3]][31:0]);
    end
    ctl = 0;
    apb(1, `DACC_APB_CTL, 0);
    do_op(DACC_OP_ADD, 0, 1, 0, 0);
    do_op(DACC_OP_ADD, 1, 1, 0, 0);
    apb(1, `DACC_APB_STAT, 32'hC);
    cl = 0;
    apb(1, `DACC_APB_TRAP, 32'h4);
    corner(8'h00, 0, `DACC_POS40, DACC_OP_ADD);
    chk(arith_trap_req, 1'b1);
    apb(1, `DACC_APB_TRAP, 32'h1);
    apb(1, `DACC_APB_STAT, 32'hC);
    cl = 0;
    do_op(DACC_OP_ADD, 0, 1, 0, 0);
    gd = 0;
    @(posedge pclk);
    chk(arith_trap_req, 1'b0);
    do_op(DACC_OP_ADD, 0, 1, 40'h0100000000, 0);
    @(posedge pclk);
    chk(arith_trap_req, 1'b1);
    apb(1, `DACC_APB_TRAP, 32'h0);
    @(posedge pclk);
    chk(arith_trap_req, 1'b0);
    corner(8'h50, 0, `DACC_POS40, DACC_OP_ADD);
    corner(8'h90, 1, `DACC_NEG40, DACC_OP_SUB);
    corner(8'h40, 0, `DACC_POS32, DACC_OP_ADD);
    corner(8'h80, 1, 40'hFF80000000, DACC_OP_SUB);
    corner(8'h00, 0, `DACC_POS32, DACC_OP_ADD);
    for (int i = 0; i < 60; i++) begin
      r = rnd32();
      w = rnd32();
      v = {{6{w[31]}}, w, 2'b00};
      ctl = r[7:0] & 8'hF2;
      apb(1, `DACC_APB_CTL, ctl);
      if (r[8]) cl = 0;
      apb(1, `DACC_APB_STAT, r[8] ? 32'hC : 32'h0);
      {b, z, wb} = r[14:12];
      c = r[16] ? DACC_OP_SUB : DACC_OP_ADD;
      wbd = ref_st(acc[!b], 1'b1);
      op_wb_mode <= r[15] ? DACC_WB_POSTINC : DACC_WB_DIRECT;
      do_op(c, b, z, v, wb);
      repeat (2) @(posedge pclk);
      if (wb && r[15]) begin
        chk(last_data, wbd);
        chk(last_addr, ptr);
        ptr = ptr + 16'h0002;
      end else if (wb) ptr = wbd;
      apb(0, `DACC_APB_WBPTR, 0);
      chk(rd, ptr);
      chk_state(b);
    end
    op_wb_mode <= DACC_WB_POSTINC;
    {op_valid, op_zero_acc, op_operand, op_writeback} <= {1'b1, 41'h0, 1'b1};
    op_code <= DACC_OP_ADD;
    repeat (2) @(posedge pclk);
    op_valid <= 0;
    repeat (2) @(posedge pclk);
    apb(0, `DACC_APB_WBPTR, 0);
    chk(rd, ptr + 16'h0004);
    complete_run();
  end
endmodule
